// ### dv/reset_combiner_status_chk.sv
// Port checker for the reset combiner.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module reset_combiner_status_chk (
  input wire clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, system_reset_out_o,
  input wire por_req_i, master_clear_pin_i, instr_reset_req_i, watchdog_timeout_i,
  input wire brownout_req_i, config_mismatch_i, trap_conflict_i, illegal_op_i,
  input wire uninit_wreg_reset_i,
  input wire [31:0] dat_o
);
  wire req_any = por_req_i | master_clear_pin_i | instr_reset_req_i | watchdog_timeout_i
    | brownout_req_i | config_mismatch_i | trap_conflict_i | illegal_op_i
    | uninit_wreg_reset_i;
  // Reset seen one edge late too: the releasing edge still launches a high output
  reg rst_q = 1'b1;
  always @(posedge clk_i) rst_q <= rst_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || rst_q);
  a_any_req: assert property (req_any |=> system_reset_out_o)
    else $error("reset not raised");
  a_idle_release: assert property (!req_any |=> !system_reset_out_o)
    else $error("reset not released");
  a_hold_req: assert property (req_any [*2] |-> system_reset_out_o)
    else $error("reset dropped early");
  a_write_quiet: assert property (cyc_i & stb_i & we_i & !req_any |=> !system_reset_out_o)
    else $error("write caused reset");
  a_ack_next: assert property (cyc_i & stb_i & !ack_o |=> ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  a_quiet_data: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("data without ack");
  a_upper_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0)
    else $error("upper data set");
endmodule
bind reset_combiner_status reset_combiner_status_chk u_chk (.*);

// ### dv/reset_sources_model.sv
// Far-side model: the nine reset requesters as level lines.
// Assumes the bench sets req_i just after a rising edge.
`timescale 1ns/1ps
module reset_sources_model (
  input wire [8:0] req_i,
  output wire [8:0] line_o
);
  // Lines idle low between requests; no glitch to keep it synchronous
  assign line_o = req_i;
endmodule

// ### dv/testbench.sv
// Self-checking bench for the reset combiner.
// Assumes the design under verilog/ and the checker bound to it.
`timescale 1ns/1ps
module testbench;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc_i = 0;
  logic stb_i = 0;
  logic we_i = 0;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] rd;
  logic [8:0] req = 9'h000;
  logic [15:0] cause [1:8] = '{16'h0080, 16'h0040, 16'h0010, 16'h0002,
    16'h0200, 16'h8000, 16'h4000, 16'h4000};
  wire [8:0] src;
  wire [31:0] dat_o;
  wire ack_o, sys, irq_o;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2 clk_i = ~clk_i;
  reset_sources_model u_reset_sources_model (.req_i(req), .line_o(src));
  reset_combiner_status u_reset_combiner_status (.clk_i(clk_i), .rst_i(rst_i),
    .por_req_i(src[0]), .master_clear_pin_i(src[1]), .instr_reset_req_i(src[2]),
    .watchdog_timeout_i(src[3]), .brownout_req_i(src[4]), .config_mismatch_i(src[5]),
    .trap_conflict_i(src[6]), .illegal_op_i(src[7]), .uninit_wreg_reset_i(src[8]),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .system_reset_out_o(sys), .irq_o(irq_o));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  // One-cycle request; reset must show while it is seen and fall after
  task pulse(input int i);
    req <= 9'h001 << i;
    @(posedge clk_i);
    req <= 9'h000;
    @(posedge clk_i);
    chk("sys high", 1, sys);
    @(posedge clk_i);
    chk("sys low", 0, sys);
  endtask
  task t_src;
    pulse(0);
    wb(0, 4'h0, 0);
    chk("por status", 16'h0003, rd);
    for (int i = 1; i <= 8; i++) begin
      wb(1, 4'h0, 0);
      pulse(i);
      wb(0, 4'h0, 0);
      chk("cause", cause[i], rd);
    end
    $display("sources done");
  endtask
  task t_sw;
    wb(1, 4'h0, 32'hFFFF);
    chk("write no reset", 0, sys);
    wb(0, 4'h0, 0);
    chk("status set", 16'hC2D3, rd);
    wb(1, 4'h0, 0);
    wb(0, 4'h0, 0);
    chk("status clear", 0, rd);
    wb(0, 4'hC, 0);
    chk("unmapped", 0, rd);
    // Upper lane only; lower byte must stay clear
    sel_i <= 4'h2;
    wb(1, 4'h0, 32'hFFFF);
    sel_i <= 4'hF;
    wb(0, 4'h0, 0);
    chk("lane write", 16'hC200, rd);
    // Source levels read back while a request is held
    req <= 9'h020;
    wb(0, 4'h8, 0);
    chk("sys held", 1, sys);
    req <= 9'h000;
    chk("levels", 32'h00000020, rd);
    $display("software done");
  endtask
  task t_irq;
    wb(1, 4'h4, 32'h10);
    pulse(3);
    chk("irq on", 1, irq_o);
    wb(1, 4'h0, 0);
    @(posedge clk_i);
    chk("irq off", 0, irq_o);
    wb(1, 4'h4, 0);
    wb(1, 4'h0, 32'h10);
    @(posedge clk_i);
    chk("irq masked", 0, irq_o);
    $display("irq done");
  endtask
  // Watchdog seen on the very edge that a clearing write lands
  task t_prio;
    fork
      wb(1, 4'h0, 0);
      begin
        req <= 9'h008;
        @(posedge clk_i);
        req <= 9'h000;
      end
    join
    wb(0, 4'h0, 0);
    chk("hw wins", 16'h0010, rd);
    $display("priority done");
  endtask
  // Mid-run reset: output held, mask and irq cleared, flags kept
  task t_rst;
    wb(1, 4'h4, 32'hFFFF);
    wb(1, 4'h0, 32'h0080);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    chk("sys in reset", 1, sys);
    chk("irq in reset", 0, irq_o);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, 4'h0, 0);
    chk("flags kept", 16'h0080, rd);
    wb(0, 4'h4, 0);
    chk("mask reset", 0, rd);
    $display("reset done");
  endtask
  task summarize;
    $display("tests %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      summarize;
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_src;
    t_sw;
    t_irq;
    t_prio;
    t_rst;
    summarize;
  end
endmodule

// ### verilog/reset_combiner_defs.vh
// Constants for the reset combiner: register offsets, status bit positions,
// reset values and the request count. Included by every design file.
`ifndef RESET_COMBINER_DEFS_VH
`define RESET_COMBINER_DEFS_VH

// ****************************************************
// Register offsets (byte addresses)
// ****************************************************
`define ADDR_CAUSE_STATUS 4'h0
`define ADDR_CAUSE_MASK 4'h4
`define ADDR_SOURCE_LEVEL 4'h8

// ****************************************************
// Status bit positions
// ****************************************************
`define BIT_POWERON 0
`define BIT_BROWNOUT 1
`define BIT_WATCHDOG 4
`define BIT_INSTR 6
`define BIT_PIN 7
`define BIT_CONFIG 9
`define BIT_ILLEGAL_OP 14
`define BIT_TRAP 15

// ****************************************************
// Values
// ****************************************************
`define STATUS_IMPL_MASK 16'hC2D3
`define STATUS_POR_VALUE 16'h0003
`define MASK_RESET_VALUE 16'h0000
`define NUM_SOURCES 9

`endif

// ### verilog/reset_combiner_status.v
// Reset combiner with cause status register on a classic Wishbone slave.
// Assumes synchronous, active-high requests and a single clock domain.
//
// Functional notes
// RL1: Nine reset requests feed one output
// RL2: Any active request asserts system reset
// RL3: Reset output forces CPU/peripheral registers
// RL4: Each reset sets its matching cause flag
// RL5: Power-on clears flags, sets bits 1:0
// RL6: Software may set or clear implemented bits
// RL7: Writing flags never causes a reset
// RL8: Software clears flags after reading them
// RL9: Trap conflict sets bit 15
// RL10: Illegal opcode or uninit pointer sets bit 14
// RL11: Configuration mismatch sets bit 9
// RL12: Master clear pin sets bit 7
// RL13: Reset instruction sets bit 6
// RL14: Watchdog timeout sets bit 4
// RL15: Hardware set beats simultaneous software write
// RL16: Output held until all sources inactive
`timescale 1ns/1ps
`include "reset_combiner_defs.vh"

module reset_combiner_status (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Reset requests
  input wire por_req_i,
  input wire master_clear_pin_i,
  input wire instr_reset_req_i,
  input wire watchdog_timeout_i,
  input wire brownout_req_i,
  input wire config_mismatch_i,
  input wire trap_conflict_i,
  input wire illegal_op_i,
  input wire uninit_wreg_reset_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // System reset and interrupt
  output wire system_reset_out_o,
  output reg irq_o
);

  // ****************************************************
  // Request combining
  // ****************************************************
  wire [8:0] req;
  wire [15:0] cause;
  wire sys_rst;

  assign req = {uninit_wreg_reset_i, illegal_op_i, trap_conflict_i, config_mismatch_i,
                brownout_req_i, watchdog_timeout_i, instr_reset_req_i,
                master_clear_pin_i, por_req_i}; // RL1

  reset_request_combiner u_comb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(req),
    .sys_rst_o(sys_rst)
  );

  reset_source_map u_map (
    .req_i(req),
    .cause_o(cause)
  );

  // Flop output drives the CPU and peripheral reset nets
  assign system_reset_out_o = sys_rst; // RL3 RL16

  // ****************************************************
  // Register file
  // ****************************************************
  reg [15:0] cause_status_reg;
  reg [15:0] cause_status_next;
  reg [15:0] cause_mask_reg;
  reg [15:0] cause_mask_next;
  reg [31:0] rdata;
  wire access;
  wire wr_status;
  wire wr_mask;

  assign access = cyc_i & stb_i & ~ack_o;
  assign wr_status = access & we_i & (adr_i == `ADDR_CAUSE_STATUS);
  assign wr_mask = access & we_i & (adr_i == `ADDR_CAUSE_MASK);

  // Byte-lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old_val;
    input [31:0] wdata;
    input [3:0] sel;
    begin
      merge16[7:0] = sel[0] ? wdata[7:0] : old_val[7:0];
      merge16[15:8] = sel[1] ? wdata[15:8] : old_val[15:8];
    end
  endfunction

  always @* begin
    cause_status_next = cause_status_reg;
    if (wr_status) begin
      // Plain read/write; writes only store, never request a reset
      cause_status_next = merge16(cause_status_reg, dat_i, sel_i) &
                          `STATUS_IMPL_MASK; // RL6 RL7
    end
    // Set after the write so a write never drops a reset cause; power-on below overrides all flags
    cause_status_next = cause_status_next | cause; // RL4 RL9 RL10 RL11 RL12 RL13 RL14 RL15
    if (por_req_i) begin
      cause_status_next = `STATUS_POR_VALUE; // RL5
    end
  end

  always @* begin
    cause_mask_next = cause_mask_reg;
    if (wr_mask) begin
      cause_mask_next = merge16(cause_mask_reg, dat_i, sel_i) & `STATUS_IMPL_MASK;
    end
  end

  always @* begin
    rdata = 32'h00000000;
    case (adr_i)
      `ADDR_CAUSE_STATUS: rdata[15:0] = cause_status_reg;
      `ADDR_CAUSE_MASK: rdata[15:0] = cause_mask_reg;
      `ADDR_SOURCE_LEVEL: rdata[8:0] = req;
      default: rdata = 32'h00000000;
    endcase
  end

  // Status survives every reset but power-on, so rst_i leaves it alone;
  // the power-on request itself initialises it.
  always @(posedge clk_i) begin
    cause_status_reg <= cause_status_next; // RL5
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cause_mask_reg <= `MASK_RESET_VALUE;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      irq_o <= 1'b0;
    end else begin
      cause_mask_reg <= cause_mask_next;
      ack_o <= access;
      dat_o <= access ? rdata : 32'h00000000;
      irq_o <= |(cause_status_next & cause_mask_next);
    end
  end

endmodule

// ### verilog/reset_request_combiner.v
// Registers the OR of all reset requests into the system reset level.
// Assumes requests are synchronous to clk_i.
`timescale 1ns/1ps
`include "reset_combiner_defs.vh"

module reset_request_combiner (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Requests
  input wire [8:0] req_i,
  // Combined reset
  output reg sys_rst_o
);

  always @(posedge clk_i) begin
    if (rst_i) begin
      sys_rst_o <= 1'b1;
    end else begin
      // Held while any source stays active, released one clock after the last
      sys_rst_o <= |req_i; // RL2
    end
  end

endmodule

// ### verilog/reset_source_map.v
// Maps the nine reset requests to the cause-status bit layout.
// Assumes all requests are synchronous to clk_i and active high.
`timescale 1ns/1ps
`include "reset_combiner_defs.vh"

module reset_source_map (
  // Requests: 0 power-on, 1 pin, 2 instr, 3 watchdog, 4 brownout,
  // 5 config, 6 trap, 7 illegal op, 8 uninit wreg
  input wire [8:0] req_i,
  // Cause bits in status layout
  output reg [15:0] cause_o
);

  always @* begin
    cause_o = 16'h0000;
    cause_o[`BIT_POWERON] = req_i[0];
    cause_o[`BIT_PIN] = req_i[1];
    cause_o[`BIT_INSTR] = req_i[2];
    cause_o[`BIT_WATCHDOG] = req_i[3];
    cause_o[`BIT_BROWNOUT] = req_i[4] | req_i[0];
    cause_o[`BIT_CONFIG] = req_i[5];
    cause_o[`BIT_TRAP] = req_i[6];
    cause_o[`BIT_ILLEGAL_OP] = req_i[7] | req_i[8];
  end

endmodule
